// [logic/pmic_ctrl_regs.sv]
// Purpose: control, status, GPIO and charger mask registers
// Assumes: register port synchronous, one access per cycle
// Notes: read data appears one cycle after reg_rd
`timescale 1ns/1ps
`default_nettype none
`include "pmic_params.svh"
module pmic_ctrl_regs import pmic_pkg::*; #(
    parameter bit HAS_AMP = 1'b1,
    parameter int SHORT_DELAY_CYCLES = `RST_SHORT_MS * `KHZ_PER_MHZ * `CLOCK_MHZ,
    parameter int LONG_DELAY_CYCLES = `RST_LONG_MS * `KHZ_PER_MHZ * `CLOCK_MHZ,
    parameter int DEBOUNCE_CYCLES = `DEBOUNCE_MS * `KHZ_PER_MHZ * `CLOCK_MHZ
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic uvlo,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic buck_good,
    input wire logic linreg_good,
    input wire logic button_input_pin_n,
    input wire logic charger_input_good,
    input wire logic [7:0] charger_events,
    input wire logic [3:0] gpio_in,
    output logic [3:0] gpio_out,
    output logic [3:0] gpio_oe,
    output logic [1:0] led_current_mode,
    output logic forced_pwm,
    output logic rails_enable,
    output logic measure_source_select,
    output logic measure_amp_enable,
    output logic reset_delay_long,
    output logic system_reset_n,
    output logic event_pending
);
    if (SHORT_DELAY_CYCLES < 1 || SHORT_DELAY_CYCLES >= (1 << `DELAY_W)) begin : bad_short
        $error("pmic_ctrl_regs: SHORT_DELAY_CYCLES out of range");
    end
    if (LONG_DELAY_CYCLES < 1 || LONG_DELAY_CYCLES >= (1 << `DELAY_W)) begin : bad_long
        $error("pmic_ctrl_regs: LONG_DELAY_CYCLES out of range");
    end

    localparam core_state_type RESET_STATE = '{
        forced_pwm: `DEF_PWM,
        hold: `DEF_HOLD,
        mux_sel: `DEF_MUX,
        amp_en: `DEF_AMP,
        delay_long: `DEF_DELAY,
        data: `DEF_DATA,
        dir: `DEF_DIR,
        led: `DEF_LED,
        mask: `DEF_MASK,
        status: 8'h00,
        ev_prev: 8'h00,
        rdata: 8'h00,
        seq: SEQ_HOLD,
        count: '0,
        rails_en: 1'h0,
        amp_out: 1'h0,
        mux_out: 1'h0,
        rst_n_out: 1'h0,
        pin_oe: 4'h0,
        pin_level: 4'h0,
        pending: 1'h0
    };

    core_state_type state_reg;
    core_state_type state_next;

    button_if btn ();

    // button level goes straight to the debouncer
    assign btn.raw_n = button_input_pin_n;

    button_debounce #(
        .STABLE_CYCLES(DEBOUNCE_CYCLES)
    ) debounce_inst (
        .clock(clock),
        .nrst(nrst),
        .uvlo(uvlo),
        .btn(btn)
    );

    // address match shared by the write and read paths
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    logic buck_bad;
    logic linreg_bad;
    logic [7:0] ev_edges;
    logic [7:0] ev_set;
    logic [7:0] ev_clear;
    logic rails_ok;

    // power-bad also reads one while the rails are switched off
    assign buck_bad = !(buck_good && state_reg.rails_en);
    assign linreg_bad = !(linreg_good && state_reg.rails_en);
    assign rails_ok = state_reg.rails_en && buck_good && linreg_good;

    // rising edges for all events, both edges for charge-active and input-good
    assign ev_edges = (charger_events & ~state_reg.ev_prev)
        | ((charger_events ^ state_reg.ev_prev) & `BOTH_EDGE_EVENTS);
    assign ev_set = ev_edges & ~state_reg.mask;
    assign ev_clear = (reg_rd && hit(reg_addr, `ADDR_CHG_STATUS)) ? 8'hff : 8'h00;

    always_comb begin
        state_next = state_reg;
        state_next.ev_prev = charger_events;

        // register writes; unused bits have no storage so writes vanish
        if (reg_wr) begin
            if (hit(reg_addr, `ADDR_CTRL0)) begin
                state_next.forced_pwm = reg_wdata[`BIT_PWM];
            end
            if (hit(reg_addr, `ADDR_CTRL1)) begin
                state_next.hold = reg_wdata[`BIT_HOLD];
                state_next.mux_sel = reg_wdata[`BIT_MUX];
                state_next.amp_en = reg_wdata[`BIT_AMP];
                state_next.delay_long = reg_wdata[`BIT_DELAY];
            end
            if (hit(reg_addr, `ADDR_GPIO_DATA)) begin
                state_next.data = reg_wdata[3:0];
            end
            if (hit(reg_addr, `ADDR_GPIO_DIR)) begin
                state_next.led = {reg_wdata[`BIT_LED3], reg_wdata[`BIT_LED2]};
                state_next.dir = reg_wdata[3:0];
            end
            if (hit(reg_addr, `ADDR_CHG_MASK)) begin
                state_next.mask = reg_wdata;
            end
        end

        // a new event in the read cycle survives the clear
        state_next.status = (state_reg.status & ~ev_clear) | ev_set;
        state_next.pending = |state_next.status;

        // read data is captured now and presented next cycle
        if (reg_rd) begin
            if (hit(reg_addr, `ADDR_CTRL0)) begin
                state_next.rdata = {state_reg.forced_pwm, buck_bad, linreg_bad, 5'h00};
            end else if (hit(reg_addr, `ADDR_CTRL1)) begin
                state_next.rdata = {2'h0, state_reg.hold, btn.pressed, 1'h0,
                    state_reg.mux_sel, state_reg.amp_en, state_reg.delay_long};
            end else if (hit(reg_addr, `ADDR_GPIO_DATA)) begin
                state_next.rdata = {4'h0, gpio_in};
            end else if (hit(reg_addr, `ADDR_GPIO_DIR)) begin
                state_next.rdata = {state_reg.led, 2'h0, state_reg.dir};
            end else if (hit(reg_addr, `ADDR_CHG_MASK)) begin
                state_next.rdata = state_reg.mask;
            end else if (hit(reg_addr, `ADDR_CHG_STATUS)) begin
                state_next.rdata = state_reg.status;
            end else begin
                state_next.rdata = 8'h00;
            end
        end

        // rail enable and measurement controls
        state_next.rails_en = state_reg.hold | btn.pressed;
        state_next.mux_out = HAS_AMP & state_reg.mux_sel;
        state_next.amp_out = HAS_AMP & (state_reg.amp_en | charger_input_good);

        // open-drain pins: only ever pull low, release means high impedance
        for (int i = 0; i < 4; i++) begin
            state_next.pin_oe[i] = !state_reg.dir[i] && !state_reg.data[i];
        end
        // LED mode overrides direction on the two upper pins
        if (state_reg.led[0]) begin
            state_next.pin_oe[2] = !state_reg.data[2];
        end
        if (state_reg.led[1]) begin
            state_next.pin_oe[3] = !state_reg.data[3];
        end

        // output reset held for the chosen delay once both rails are good
        unique case (state_reg.seq)
            SEQ_HOLD: begin
                state_next.rst_n_out = 1'h0;
                if (rails_ok) begin
                    state_next.seq = SEQ_DELAY;
                    state_next.count = state_reg.delay_long
                        ? `DELAY_W'(LONG_DELAY_CYCLES - 1)
                        : `DELAY_W'(SHORT_DELAY_CYCLES - 1);
                end
            end
            SEQ_DELAY: begin
                if (!rails_ok) begin
                    state_next.seq = SEQ_HOLD;
                end else if (state_reg.count == '0) begin
                    state_next.seq = SEQ_RUN;
                    state_next.rst_n_out = 1'h1;
                end else begin
                    state_next.count = state_reg.count - `DELAY_W'(1);
                end
            end
            SEQ_RUN: begin
                if (!rails_ok) begin
                    state_next.seq = SEQ_HOLD;
                    state_next.rst_n_out = 1'h0;
                end
            end
        endcase
    end

    // undervoltage and reset both reload every default
    always_ff @(posedge clock) begin
        if (!nrst || uvlo) begin
            state_reg <= RESET_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata = state_reg.rdata;
    assign gpio_out = state_reg.pin_level;
    assign gpio_oe = state_reg.pin_oe;
    assign led_current_mode = state_reg.led;
    assign forced_pwm = state_reg.forced_pwm;
    assign rails_enable = state_reg.rails_en;
    assign measure_source_select = state_reg.mux_out;
    assign measure_amp_enable = state_reg.amp_out;
    assign reset_delay_long = state_reg.delay_long;
    assign system_reset_n = state_reg.rst_n_out;
    assign event_pending = state_reg.pending;

    // checks, all in the clock domain, idle during either reset except defaults_a
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst || uvlo);

    pwm_write_a: assert property (
        reg_wr && reg_addr == `ADDR_CTRL0 |=> forced_pwm == $past(reg_wdata[`BIT_PWM])
    ) else $error("forced pwm bit not taken");

    buck_flag_a: assert property (
        reg_rd && reg_addr == `ADDR_CTRL0
        |=> reg_rdata[`BIT_BUCK_BAD] == !($past(buck_good) && $past(rails_enable))
    ) else $error("buck power-bad flag wrong");

    linreg_flag_a: assert property (
        reg_rd && reg_addr == `ADDR_CTRL0
        |=> reg_rdata[`BIT_LIN_BAD] == !($past(linreg_good) && $past(rails_enable))
    ) else $error("linear regulator power-bad flag wrong");

    rails_or_a: assert property (
        (state_reg.hold || btn.pressed) |=> rails_enable
    ) else $error("rails not enabled by hold or button");

    rails_off_a: assert property (
        !state_reg.hold && !btn.pressed |=> !rails_enable
    ) else $error("rails on with hold and button both low");

    button_stat_a: assert property (
        reg_rd && reg_addr == `ADDR_CTRL1 |=> reg_rdata[`BIT_BUTTON] == $past(btn.pressed)
    ) else $error("button status read wrong");

    mux_route_a: assert property (
        reg_wr && reg_addr == `ADDR_CTRL1
        |=> ##1 measure_source_select == (HAS_AMP && $past(reg_wdata[`BIT_MUX], 2))
    ) else $error("measurement mux not following select bit");

    amp_auto_a: assert property (
        HAS_AMP && (charger_input_good || state_reg.amp_en) |=> measure_amp_enable
    ) else $error("amplifier not enabled");

    delay_load_a: assert property (
        state_reg.seq == SEQ_HOLD && rails_ok
        |=> state_reg.count == ($past(state_reg.delay_long) ? `DELAY_W'(LONG_DELAY_CYCLES - 1)
                                                             : `DELAY_W'(SHORT_DELAY_CYCLES - 1))
    ) else $error("reset delay loaded with wrong length");

    release_order_a: assert property (
        $rose(system_reset_n) |-> $past(state_reg.seq) == SEQ_DELAY && $past(state_reg.count) == '0
    ) else $error("output reset released before its delay ran out");

    pin_drive_a: assert property (
        !state_reg.dir[0] && !state_reg.data[0] |=> gpio_oe[0] && !gpio_out[0]
    ) else $error("output pin with data zero not pulled low");

    pin_release_a: assert property (
        state_reg.data[1] |=> !gpio_oe[1]
    ) else $error("pin with data one still driven");

    led_sink_a: assert property (
        state_reg.led[1] && !state_reg.data[3] |=> gpio_oe[3] && led_current_mode[1]
    ) else $error("LED pin not sinking current");

    input_release_a: assert property (
        state_reg.dir[0] |=> !gpio_oe[0]
    ) else $error("input pin driven");

    mask_block_a: assert property (
        state_reg.mask[7] && !state_reg.status[7] |=> !state_reg.status[7]
    ) else $error("masked event set status");

    status_set_a: assert property (
        charger_events[0] && !state_reg.ev_prev[0] && !state_reg.mask[0] |=> state_reg.status[0]
    ) else $error("unmasked event lost");

    both_edge_a: assert property (
        $fell(charger_events[2]) && !state_reg.mask[2] |-> ##1 state_reg.status[2]
    ) else $error("falling edge of input-good not caught");

    read_clear_a: assert property (
        reg_rd && reg_addr == `ADDR_CHG_STATUS && ev_set == 8'h00 |=> state_reg.status == 8'h00
    ) else $error("status not cleared by read");

    unused_zero_a: assert property (
        reg_rd && reg_addr == `ADDR_GPIO_DIR |=> reg_rdata[5:4] == 2'h0
    ) else $error("unused bits read non-zero");

    defaults_a: assert property (@(posedge clock) disable iff (1'b0)
        !nrst || uvlo |=> state_reg.mask == `DEF_MASK && state_reg.dir == `DEF_DIR
            && state_reg.led == `DEF_LED && state_reg.data == `DEF_DATA
            && state_reg.mux_sel == `DEF_MUX && state_reg.delay_long == `DEF_DELAY
    ) else $error("defaults not reloaded on reset");

    status_seen_c: cover property (ev_set != 8'h00 ##1 reg_rd && reg_addr == `ADDR_CHG_STATUS);
    reset_release_c: cover property ($rose(system_reset_n));
    led_on_c: cover property (gpio_oe[2] && led_current_mode[0]);
    button_rail_c: cover property (!state_reg.hold && btn.pressed ##1 rails_enable);
endmodule : pmic_ctrl_regs
`default_nettype wire

// [logic/pmic_params.svh]
// Purpose: constants of the power-control register bank
// Assumes: 200 MHz clock, byte-wide register port
// Notes: offsets are byte addresses of the register port
`ifndef PMIC_PARAMS_SVH
`define PMIC_PARAMS_SVH
`define CLOCK_MHZ 200
`define KHZ_PER_MHZ 1000
`define RST_SHORT_MS 11
`define RST_LONG_MS 90
`define DEBOUNCE_MS 30
`define DELAY_W 25
`define ADDR_CTRL0 8'h09
`define ADDR_CTRL1 8'h0a
`define ADDR_GPIO_DATA 8'h0b
`define ADDR_GPIO_DIR 8'h0c
`define ADDR_CHG_MASK 8'h0d
`define ADDR_CHG_STATUS 8'h10
`define BIT_PWM 7
`define BIT_BUCK_BAD 6
`define BIT_LIN_BAD 5
`define BIT_HOLD 5
`define BIT_BUTTON 4
`define BIT_MUX 2
`define BIT_AMP 1
`define BIT_DELAY 0
`define BIT_LED3 7
`define BIT_LED2 6
`define DEF_PWM 1'h0
`define DEF_HOLD 1'h0
`define DEF_MUX 1'h1
`define DEF_AMP 1'h0
`define DEF_DELAY 1'h1
`define DEF_DATA 4'hf
`define DEF_DIR 4'h3
`define DEF_LED 2'h3
`define DEF_MASK 8'hff
`define BOTH_EDGE_EVENTS 8'h0c
`endif

// [logic/pmic_pkg.sv]
// Purpose: state types of the power-control register bank
// Assumes: widths come from pmic_params.svh
// Notes: one packed struct per module holds all its state
`default_nettype none
`include "pmic_params.svh"
package pmic_pkg;
    typedef enum logic [1:0] {SEQ_HOLD, SEQ_DELAY, SEQ_RUN} seq_type;

    typedef struct packed {
        logic forced_pwm;
        logic hold;
        logic mux_sel;
        logic amp_en;
        logic delay_long;
        logic [3:0] data;
        logic [3:0] dir;
        logic [1:0] led;
        logic [7:0] mask;
        logic [7:0] status;
        logic [7:0] ev_prev;
        logic [7:0] rdata;
        seq_type seq;
        logic [`DELAY_W-1:0] count;
        logic rails_en;
        logic amp_out;
        logic mux_out;
        logic rst_n_out;
        logic [3:0] pin_oe;
        logic [3:0] pin_level;
        logic pending;
    } core_state_type;

    typedef struct packed {
        logic stable;
        logic [`DELAY_W-1:0] count;
    } bounce_state_type;
endpackage : pmic_pkg
`default_nettype wire

// [logic/button_if.sv]
// Purpose: raw button level in, debounced press out
// Assumes: raw level already synchronous to the clock
// Notes: the button pin is active low
`timescale 1ns/1ps
`default_nettype none
interface button_if;
    logic raw_n;
    logic pressed;
    modport debounce (input raw_n, output pressed);
    modport user (output raw_n, input pressed);
endinterface : button_if
`default_nettype wire

// [logic/button_debounce.sv]
// Purpose: debounce the push-button level
// Assumes: button pin active low, synchronous input
// Notes: a new level must hold STABLE_CYCLES cycles to be accepted
`timescale 1ns/1ps
`default_nettype none
`include "pmic_params.svh"
module button_debounce import pmic_pkg::*; #(
    parameter int STABLE_CYCLES = `DEBOUNCE_MS * `KHZ_PER_MHZ * `CLOCK_MHZ
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic uvlo,
    button_if.debounce btn
);
    if (STABLE_CYCLES < 1 || STABLE_CYCLES >= (1 << `DELAY_W)) begin : bad_stable
        $error("button_debounce: STABLE_CYCLES out of range");
    end

    bounce_state_type state_reg;
    bounce_state_type state_next;

    // count only while the raw level disagrees; any bounce restarts it
    always_comb begin
        state_next = state_reg;
        if (!btn.raw_n != state_reg.stable) begin
            if (state_reg.count == `DELAY_W'(STABLE_CYCLES - 1)) begin
                state_next.stable = !btn.raw_n;
                state_next.count = '0;
            end else begin
                state_next.count = state_reg.count + `DELAY_W'(1);
            end
        end else begin
            state_next.count = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst || uvlo) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign btn.pressed = state_reg.stable;
endmodule : button_debounce
`default_nettype wire

// [tb/rail_pin_model.sv]
// Purpose: regulators and open-drain pins seen by the register bank
// Assumes: rails come good one cycle after enable and drop the same way
// Notes: pins carry pull-ups, so a released pin reads high, never stale
`timescale 1ns/1ps
`default_nettype none
module rail_pin_model (
    input wire logic clock,
    input wire logic rails_enable,
    input wire logic [3:0] gpio_oe,
    input wire logic [3:0] ext_low,
    output logic buck_good,
    output logic linreg_good,
    output logic [3:0] gpio_in
);
    // regulators lag the enable by a cycle, like a soft start
    always_ff @(posedge clock) begin
        buck_good <= rails_enable;
        linreg_good <= rails_enable;
    end
    // wired level: any party pulling low wins, else the pull-up
    assign gpio_in = ~(gpio_oe | ext_low);
endmodule : rail_pin_model
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: register-level bench for the power-control register bank
// Assumes: delay and debounce counts shortened by parameter
// Notes: all inputs change on the falling edge of the clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock, nrst, uvlo, reg_wr, reg_rd, btn_n, chg_good;
    logic [7:0] addr, wdata, rdata, events;
    logic buck_good, linreg_good, rails, pwm, mux, amp, dly, sys_n, pend;
    logic [3:0] gin, gout, goe, ext_low;
    logic [1:0] led;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int n_short, n_long;

    pmic_ctrl_regs #(
        .SHORT_DELAY_CYCLES(5),
        .LONG_DELAY_CYCLES(9),
        .DEBOUNCE_CYCLES(3)
    ) u_dut (
        .clock(clock), .nrst(nrst), .uvlo(uvlo),
        .reg_addr(addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(wdata), .reg_rdata(rdata),
        .buck_good(buck_good), .linreg_good(linreg_good),
        .button_input_pin_n(btn_n), .charger_input_good(chg_good),
        .charger_events(events), .gpio_in(gin), .gpio_out(gout),
        .gpio_oe(goe), .led_current_mode(led), .forced_pwm(pwm),
        .rails_enable(rails), .measure_source_select(mux),
        .measure_amp_enable(amp), .reset_delay_long(dly),
        .system_reset_n(sys_n), .event_pending(pend)
    );

    rail_pin_model u_model (
        .clock(clock), .rails_enable(rails), .gpio_oe(goe), .ext_low(ext_low),
        .buck_good(buck_good), .linreg_good(linreg_good), .gpio_in(gin)
    );

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // hang guard, well above the few hundred cycles the tests need
    always @(posedge clock) begin
        cyc++;
        if (cyc == 4000) begin
            bad_count++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask : wt

    // one write; strobe drops for a full cycle so calls may follow at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        @(negedge clock);
    endtask : wr

    // read data is sampled a full cycle after the strobe, where it stands
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        @(negedge clock);
        chk(rdata, exp, "read data");
    endtask : rd

    // cycles until the system reset is released, bounded
    task automatic wait_sys(output int n);
        n = 0;
        while (sys_n !== 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        chk(8'(sys_n), 8'h01, "system reset release");
    endtask : wait_sys

    initial begin
        nrst = 1'b0;
        uvlo = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        btn_n = 1'b1;
        chg_good = 1'b0;
        events = 8'h00;
        ext_low = 4'h0;
        repeat (6) @(negedge clock);
        nrst = 1'b1;
        @(negedge clock);
        // defaults after reset
        rd(8'h09, 8'h60);
        rd(8'h0a, 8'h05);
        rd(8'h0b, 8'h0f);
        rd(8'h0c, 8'hc3);
        rd(8'h0d, 8'hff);
        chk(8'(led), 8'h03, "led mode");
        chk(8'(goe), 8'h00, "pin drive");
        chk(8'(pwm), 8'h00, "pwm");
        chk(8'(dly), 8'h01, "delay select");
        // read-only and unused bits, unmapped address
        wr(8'h09, 8'hff);
        rd(8'h09, 8'he0);
        chk(8'(pwm), 8'h01, "pwm");
        wr(8'h20, 8'h55);
        rd(8'h20, 8'h00);
        wr(8'h0a, 8'hd8);
        rd(8'h0a, 8'h00);
        // hold on with short delay, then the amplifier rules
        wr(8'h0a, 8'h20);
        wait_sys(n_short);
        // one cycle of rail start-up, one load cycle, then the short count
        chk(8'(n_short), 8'h07, "short delay length");
        chk(8'(rails), 8'h01, "rails on");
        rd(8'h09, 8'h80);
        chk(8'(mux), 8'h00, "mux battery");
        chk(8'(amp), 8'h00, "amp off");
        chg_good = 1'b1;
        wt(3);
        chk(8'(amp), 8'h01, "amp auto");
        chg_good = 1'b0;
        wr(8'h0a, 8'h07);
        wt(2);
        chk(8'(rails), 8'h00, "rails off");
        chk(8'(sys_n), 8'h00, "reset on rail loss");
        chk({6'h00, mux, amp}, 8'h03, "mux and amp");
        rd(8'h09, 8'he0);
        // long delay must take exactly the extra count
        wr(8'h0a, 8'h21);
        wait_sys(n_long);
        chk(8'(n_long - n_short), 8'h04, "delay difference");
        // push-button alone powers the rails
        wr(8'h0a, 8'h01);
        btn_n = 1'b0;
        wt(8);
        rd(8'h0a, 8'h11);
        chk(8'(rails), 8'h01, "rails by button");
        btn_n = 1'b1;
        wt(8);
        rd(8'h0a, 8'h01);
        chk(8'(rails), 8'h00, "rails released");
        // open-drain pins as plain outputs
        wr(8'h0c, 8'h00);
        wr(8'h0b, 8'hfa);
        wt(2);
        chk(8'(goe), 8'h05, "pins driven low");
        chk(8'(led), 8'h00, "led mode off");
        chk(8'(gout), 8'h00, "pin drive value");
        rd(8'h0b, 8'h0a);
        // LED driver pins with every direction set to input
        wr(8'h0c, 8'hcf);
        wr(8'h0b, 8'h03);
        wt(2);
        chk(8'(goe), 8'h0c, "led sinks");
        ext_low = 4'h1;
        wt(2);
        rd(8'h0b, 8'h02);
        ext_low = 4'h0;
        rd(8'h0c, 8'hcf);
        // fully masked events leave the status clear
        events = 8'hff;
        wt(3);
        events = 8'h00;
        wt(3);
        rd(8'h10, 8'h00);
        // one open mask bit at a time, all events toggled
        for (int i = 0; i < 8; i++) begin
            wr(8'h0d, ~(8'h01 << i));
            events = 8'hff;
            wt(3);
            chk(8'(pend), 8'h01, "pending");
            rd(8'h10, 8'h01 << i);
            events = 8'h00;
            wt(3);
            rd(8'h10, (i == 2 || i == 3) ? (8'h01 << i) : 8'h00);
        end
        wt(2);
        chk(8'(pend), 8'h00, "pending cleared");
        // undervoltage in mid-run reloads the defaults
        uvlo = 1'b1;
        wt(2);
        uvlo = 1'b0;
        wt(1);
        rd(8'h09, 8'h60);
        rd(8'h0c, 8'hc3);
        rd(8'h0d, 8'hff);
        rd(8'h0b, 8'h0f);
        results();
    end
endmodule : tb_top
`default_nettype wire
